// File: rtl/thermal_pin_config_registers.v
`timescale 1ns/1ps
`include "thermal_pin_config_defines.vh"

module thermal_pin_config_registers
#(
  parameter UNIT_CYCLES = `TIMER_UNIT_CYCLES
)
(
  // Clock and reset.
  input  wire       mclk,
  input  wire       rst,
  // Register port from the serial interface.
  input  wire [7:0] reg_addr,
  input  wire [7:0] reg_wdata,
  input  wire       reg_wr,
  input  wire       reg_rd,
  output reg  [7:0] reg_rdata,
  // Format configuration lock bit (gates writes to 0x7C only) and interrupt status clear.
  input  wire       config_lock,
  input  wire       flag_clear,
  output reg        overtemp_time_flag,
  // Over-temperature pin, open drain, active low.
  input  wire       overtemp_signal_in,
  output reg        overtemp_signal_out,
  output reg        overtemp_signal_oe,
  // Temperature readings and over-temperature limits.
  input  wire [7:0] local_temp,
  input  wire [7:0] remote_one_temp,
  input  wire [7:0] remote_two_temp,
  input  wire [7:0] local_limit,
  input  wire [7:0] remote_one_limit,
  input  wire [7:0] remote_two_limit,
  // Spare pin.
  input  wire       spare_pin_enable,
  input  wire       spare_pin_assert,
  input  wire       spare_pin_io_in,
  output reg        spare_pin_io_out,
  output reg        spare_pin_io_oe,
  output reg        spare_pin_level,
  // Configuration seen by the rest of the chip.
  output reg        signed_format_select,
  output reg        offset_full_degree,
  output reg        voltage_id_pin_function_select,
  output reg  [2:0] fan_one_pulse_count,
  output reg  [2:0] fan_two_pulse_count,
  output reg  [2:0] fan_three_pulse_count,
  output reg  [2:0] fan_four_pulse_count
);

  reg  [7:0] assert_time_limit_field;
  reg  [7:0] tach_pulse_count_select;
  reg  [7:0] format_and_pin_config;

  // Three-stage synchronisers for the two pins.
  reg  [2:0] overtemp_sync;
  reg  [2:0] spare_sync;
  reg        overtemp_level;
  reg        spare_in_level;
  reg        overtemp_level_d;

  wire [7:0] assertion_duration_count;
  wire       assertion_seen_bit;
  wire       status_read;
  wire [7:0] timer_status;
  wire       local_hot;
  wire       remote_one_hot;
  wire       remote_two_hot;
  wire       any_hot;
  wire       limit_exceeded;
  wire       zero_limit_hit;
  wire       spare_out_level;
  wire [4*`FAN_COUNT_W-1:0] next_fan_counts;
  wire [`FAN_COUNT_W-1:0]   fan_counts [0:3];

  // Compare a reading with a limit in the currently selected format.
  function exceeds;
    input [7:0] temp;
    input [7:0] limit;
    input       twos;
    begin
      // Flipping the sign bit turns a signed compare into an unsigned one.
      if (twos)
        exceeds = ((temp ^ `SIGN_FLIP) > (limit ^ `SIGN_FLIP));
      else
        exceeds = (temp > limit);
    end
  endfunction

  // A limit at the format's minimum disables that channel.
  function limit_disabled;
    input [7:0] limit;
    input       twos;
    begin
      if (twos)
        limit_disabled = (limit == `MIN_TWOS_RAW);
      else
        limit_disabled = (limit == `MIN_OFFSET64_RAW);
    end
  endfunction

  // Per-channel output drive.
  function channel_hot;
    input [7:0] temp;
    input [7:0] limit;
    input       enable;
    input       twos;
    begin
      channel_hot = enable && !limit_disabled(limit, twos) && exceeds(temp, limit, twos);
    end
  endfunction

  assign local_hot      = channel_hot(local_temp, local_limit,
                            format_and_pin_config[`CFG_LOCAL_OE],
                            format_and_pin_config[`CFG_SIGNED_FORMAT]);
  assign remote_one_hot = channel_hot(remote_one_temp, remote_one_limit,
                            format_and_pin_config[`CFG_REMOTE_ONE_OE],
                            format_and_pin_config[`CFG_SIGNED_FORMAT]);
  assign remote_two_hot = channel_hot(remote_two_temp, remote_two_limit,
                            format_and_pin_config[`CFG_REMOTE_TWO_OE],
                            format_and_pin_config[`CFG_SIGNED_FORMAT]);
  assign any_hot        = local_hot | remote_one_hot | remote_two_hot;

  // Timer status reads the seen bit alone until two units have elapsed.
  assign timer_status = (assertion_duration_count >= `TIMER_REPORT_MIN) ?
                        assertion_duration_count :
                        {7'h00, assertion_seen_bit};
  assign status_read  = reg_rd && (reg_addr == `ADDR_TIMER_STATUS);

  // A non-zero limit is judged in whole timer units; zero uses the edge path below.
  assign limit_exceeded = (assert_time_limit_field != `ZERO_BYTE) &&
                          (assertion_duration_count > assert_time_limit_field);
  assign zero_limit_hit = (assert_time_limit_field == `ZERO_BYTE) &&
                          overtemp_level && !overtemp_level_d;

  assign spare_out_level = spare_pin_assert ~^
                           format_and_pin_config[`CFG_SPARE_POLARITY];

  genvar fan;
  generate
    for (fan = 0; fan < 4; fan = fan + 1)
    begin : fan_decode
      assign fan_counts[fan] = {1'b0, tach_pulse_count_select[
                                 fan*`FAN_FIELD_W +: `FAN_FIELD_W]}
                               + `FAN_COUNT_BASE;
    end
  endgenerate
  assign next_fan_counts = {fan_counts[3], fan_counts[2], fan_counts[1], fan_counts[0]};

  overtemp_duration_timer
  #(
    .UNIT_CYCLES (UNIT_CYCLES)
  )
  u_timer
  (
    .mclk                     (mclk),
    .rst                      (rst),
    .asserted                 (overtemp_level),
    .clear                    (status_read),
    .assertion_duration_count (assertion_duration_count),
    .assertion_seen_bit       (assertion_seen_bit)
  );

  // Pin synchronisers; a level changes only when stages two and three agree.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      overtemp_sync    <= 3'h7;
      spare_sync       <= 3'h0;
      overtemp_level   <= 1'b0;
      overtemp_level_d <= 1'b0;
      spare_in_level   <= 1'b0;
    end
    else
    begin
      overtemp_sync    <= {overtemp_sync[1:0], overtemp_signal_in};
      spare_sync       <= {spare_sync[1:0], spare_pin_io_in};
      // The pin is active low, so both stages low means asserted.
      if (overtemp_sync[1] == overtemp_sync[2])
        overtemp_level <= ~overtemp_sync[2];
      if (spare_sync[1] == spare_sync[2])
        spare_in_level <= spare_sync[2];
      overtemp_level_d <= overtemp_level;
    end
  end

  // Register writes.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      assert_time_limit_field <= `RST_TIME_LIMIT;
      tach_pulse_count_select <= `RST_PULSE_SELECT;
      format_and_pin_config   <= `RST_FORMAT_CONFIG;
    end
    else if (reg_wr)
    begin
      case (reg_addr)
        `ADDR_TIME_LIMIT:
          assert_time_limit_field <= reg_wdata;
        `ADDR_PULSE_SELECT:
          tach_pulse_count_select <= reg_wdata;
        `ADDR_FORMAT_CONFIG:
          // A locked configuration keeps its value; the write is dropped silently.
          if (!config_lock)
            format_and_pin_config <= reg_wdata;
        default:
          assert_time_limit_field <= assert_time_limit_field;
      endcase
    end
  end

  // Register reads; unmapped offsets return zero.
  always @(posedge mclk)
  begin
    if (rst)
      reg_rdata <= `RST_BYTE;
    else if (reg_rd)
    begin
      case (reg_addr)
        `ADDR_TIMER_STATUS:
          reg_rdata <= timer_status;
        `ADDR_TIME_LIMIT:
          reg_rdata <= assert_time_limit_field;
        `ADDR_PULSE_SELECT:
          reg_rdata <= tach_pulse_count_select;
        `ADDR_FORMAT_CONFIG:
          reg_rdata <= format_and_pin_config;
        default:
          reg_rdata <= `ZERO_BYTE;
      endcase
    end
  end

  // Interrupt flag; a new event in the clearing cycle wins over the clear.
  always @(posedge mclk)
  begin
    if (rst)
      overtemp_time_flag <= 1'b0;
    else if (limit_exceeded || zero_limit_hit)
      overtemp_time_flag <= 1'b1;
    else if (flag_clear)
      overtemp_time_flag <= 1'b0;
  end

  // Over-temperature pin drive, registered.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      overtemp_signal_out <= 1'b0;
      overtemp_signal_oe  <= 1'b0;
    end
    else
    begin
      // Open drain: the pin is only ever pulled low, never driven high.
      overtemp_signal_out <= 1'b0;
      // The drive lags the compare by one cycle so the pin never glitches.
      overtemp_signal_oe  <= any_hot;
    end
  end

  // Spare pin drive and its sampled level.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      spare_pin_io_out <= 1'b0;
      spare_pin_io_oe  <= 1'b0;
      spare_pin_level  <= 1'b0;
    end
    else
    begin
      spare_pin_io_out <= spare_out_level;
      spare_pin_io_oe  <= spare_pin_enable &&
                          format_and_pin_config[`CFG_SPARE_DIRECTION];
      // The level is registered once more so the output is a plain flip-flop.
      spare_pin_level  <= spare_in_level;
    end
  end

  // Configuration copies seen by the rest of the chip.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      signed_format_select           <= 1'b1;
      offset_full_degree             <= 1'b0;
      voltage_id_pin_function_select <= 1'b0;
    end
    else
    begin
      signed_format_select           <= format_and_pin_config[`CFG_SIGNED_FORMAT];
      offset_full_degree             <= format_and_pin_config[`CFG_OFFSET_SCALE];
      voltage_id_pin_function_select <= format_and_pin_config[`CFG_VID_FUNCTION];
    end
  end

  // Fan pulse counts; users see a count, never the raw two-bit code.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      fan_one_pulse_count   <= `FAN_COUNT_BASE;
      fan_two_pulse_count   <= `FAN_COUNT_BASE;
      fan_three_pulse_count <= `FAN_COUNT_BASE;
      fan_four_pulse_count  <= `FAN_COUNT_BASE;
    end
    else
    begin
      fan_one_pulse_count   <= next_fan_counts[0 +: `FAN_COUNT_W];
      fan_two_pulse_count   <= next_fan_counts[`FAN_COUNT_W +: `FAN_COUNT_W];
      fan_three_pulse_count <= next_fan_counts[2*`FAN_COUNT_W +: `FAN_COUNT_W];
      fan_four_pulse_count  <= next_fan_counts[3*`FAN_COUNT_W +: `FAN_COUNT_W];
    end
  end

endmodule

// File: rtl/thermal_pin_config_defines.vh
`ifndef THERMAL_PIN_CONFIG_DEFINES_VH
`define THERMAL_PIN_CONFIG_DEFINES_VH

// Register offsets.
`define ADDR_TIMER_STATUS     8'h79
`define ADDR_TIME_LIMIT       8'h7A
`define ADDR_PULSE_SELECT     8'h7B
`define ADDR_FORMAT_CONFIG    8'h7C

// Reset values.
`define RST_TIME_LIMIT        8'h00
`define RST_PULSE_SELECT      8'h55
`define RST_FORMAT_CONFIG     8'h01
`define RST_BYTE              8'h00

// Configuration field positions.
`define CFG_SIGNED_FORMAT     0
`define CFG_OFFSET_SCALE      1
`define CFG_SPARE_DIRECTION   2
`define CFG_SPARE_POLARITY    3
`define CFG_VID_FUNCTION      4
`define CFG_REMOTE_ONE_OE     5
`define CFG_LOCAL_OE          6
`define CFG_REMOTE_TWO_OE     7

// Pulse count field width, count width and the base added to each fan field.
`define FAN_FIELD_W           2
`define FAN_COUNT_W           3
`define FAN_COUNT_BASE        3'h1

// Format minimum values that disable a channel's over-temperature output.
`define MIN_OFFSET64_RAW      8'h00
`define MIN_TWOS_RAW          8'h80
`define SIGN_FLIP             8'h80

// Timing: one timer unit is 22.76 ms, the clock period is 40 ns.
`define TIMER_UNIT_NS         22760000
`define CLK_PERIOD_NS         40
`define TIMER_UNIT_CYCLES     (`TIMER_UNIT_NS / `CLK_PERIOD_NS)

// Timer status reports full count once two units (45.52 ms) have elapsed.
`define TIMER_REPORT_MIN      8'h02
`define TIMER_MAX             8'hFF
`define TIMER_ONE             8'h01
`define ZERO_BYTE             8'h00

`endif

// File: rtl/overtemp_duration_timer.v
`timescale 1ns/1ps
`include "thermal_pin_config_defines.vh"

module overtemp_duration_timer
#(
  parameter UNIT_CYCLES = `TIMER_UNIT_CYCLES
)
(
  // Clock and reset.
  input  wire       mclk,
  input  wire       rst,
  // Control.
  input  wire       asserted,
  input  wire       clear,
  // Result.
  output reg  [7:0] assertion_duration_count,
  output reg        assertion_seen_bit
);

  reg  [31:0] prescale;
  wire        unit_done;
  wire        rose;
  reg         asserted_d;

  assign unit_done = (prescale == UNIT_CYCLES - 1);
  assign rose      = asserted & ~asserted_d;

  always @(posedge mclk)
  begin
    if (rst)
    begin
      prescale                 <= 32'h0;
      asserted_d               <= 1'b0;
      assertion_duration_count <= `ZERO_BYTE;
      assertion_seen_bit       <= 1'b0;
    end
    else
    begin
      asserted_d <= asserted;
      // A fresh assertion in the clearing cycle must still be recorded.
      if (rose)
        assertion_seen_bit <= 1'b1;
      else if (clear)
        assertion_seen_bit <= 1'b0;
      if (!asserted || unit_done)
        prescale <= 32'h0;
      else
        prescale <= prescale + 32'h1;
      // The count saturates rather than wrapping so a long assertion never looks short.
      if (asserted && unit_done && assertion_duration_count != `TIMER_MAX)
        assertion_duration_count <= assertion_duration_count + `TIMER_ONE;
      else if (clear)
        assertion_duration_count <= `ZERO_BYTE;
    end
  end

endmodule

// File: dv/thermal_pin_config_asserts.sv
`timescale 1ns/1ps
module thermal_pin_config_asserts
#(
  parameter UNIT_CYCLES = 4
)
(
  // Clock, reset and register port.
  input wire logic       mclk, rst, reg_wr, reg_rd, config_lock, flag_clear,
  input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
  // Pins and flag.
  input wire logic       overtemp_time_flag, overtemp_signal_in, overtemp_signal_out,
  input wire logic       overtemp_signal_oe, spare_pin_enable, spare_pin_assert,
  input wire logic       spare_pin_io_out, spare_pin_io_oe,
  // Temperatures, limits and configuration.
  input wire logic [7:0] local_temp, remote_one_temp, remote_two_temp,
  input wire logic [7:0] local_limit, remote_one_limit, remote_two_limit,
  input wire logic       signed_format_select, voltage_id_pin_function_select,
  input wire logic [2:0] fan_one_pulse_count
);
  logic [7:0] lim;
  logic [7:0] pul;
  logic [7:0] cfg;
  logic [7:0] exp_rd;
  logic       hot;

  function automatic logic over(input logic [7:0] t, l, input logic en, tw);
    over = en && l != (tw ? 8'h80 : 8'h00) && (tw ? $signed(t) > $signed(l) : t > l);
  endfunction

  // Shadow copies predict the outputs without looking inside the block.
  always @(posedge mclk)
  begin
    if (rst)
    begin
      lim <= 8'h00;
      pul <= 8'h55;
      cfg <= 8'h01;
    end
    else if (reg_wr && reg_addr == 8'h7A)
      lim <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h7B)
      pul <= reg_wdata;
    else if (reg_wr && reg_addr == 8'h7C && !config_lock)
      cfg <= reg_wdata;
  end

  always @*
  begin
    hot = over(local_temp, local_limit, cfg[6], cfg[0])
        | over(remote_one_temp, remote_one_limit, cfg[5], cfg[0])
        | over(remote_two_temp, remote_two_limit, cfg[7], cfg[0]);
    exp_rd = reg_addr == 8'h7A ? lim : reg_addr == 8'h7B ? pul
           : reg_addr == 8'h7C ? cfg : 8'h00;
  end

  default clocking cb @(posedge mclk);
  endclocking
  default disable iff (rst);

  a_read_back:
    assert property (reg_rd && reg_addr != 8'h79 |=> reg_rdata == $past(exp_rd))
    else $error("read data differs from register");
  a_fan_field:
    assert property (reg_wr && reg_addr == 8'h7B |-> ##2
      fan_one_pulse_count == {1'b0, $past(reg_wdata[1:0], 2)} + 3'h1)
    else $error("fan pulse count wrong");
  a_cfg_apply:
    assert property (reg_wr && reg_addr == 8'h7C && !config_lock |-> ##2
      signed_format_select == $past(reg_wdata[0], 2)
      && voltage_id_pin_function_select == $past(reg_wdata[4], 2))
    else $error("configuration not applied");
  a_cfg_locked:
    assert property (reg_wr && reg_addr == 8'h7C && config_lock |-> ##2
      $stable(signed_format_select) && $stable(voltage_id_pin_function_select))
    else $error("locked configuration changed");
  a_flag_holds:
    assert property (overtemp_time_flag && !flag_clear |=> overtemp_time_flag)
    else $error("flag dropped without clear");
  a_flag_at_once:
    assert property (lim == 8'h00 && $fell(overtemp_signal_in) |-> ##[1:8] overtemp_time_flag)
    else $error("zero limit flag late");
  a_pin_drive:
    assert property (1'b1 |=> overtemp_signal_oe == $past(hot))
    else $error("pin drive wrong");
  a_pin_open_drain:
    assert property (overtemp_signal_out == 1'b0)
    else $error("pin driven high");
  a_spare_pin:
    assert property (1'b1 |=> spare_pin_io_oe == $past(spare_pin_enable & cfg[2])
      && spare_pin_io_out == $past(spare_pin_assert ~^ cfg[3]))
    else $error("spare pin wrong");

  c_lock_write: cover property (reg_wr && reg_addr == 8'h7C && config_lock);
  c_flag_rise: cover property ($rose(overtemp_time_flag));
  c_pin_rise: cover property ($rose(overtemp_signal_oe));
endmodule

bind thermal_pin_config_registers thermal_pin_config_asserts #(.UNIT_CYCLES(UNIT_CYCLES)) chk
(
  .mclk, .rst, .reg_wr, .reg_rd, .config_lock, .flag_clear, .reg_addr, .reg_wdata, .reg_rdata,
  .overtemp_time_flag, .overtemp_signal_in, .overtemp_signal_out, .overtemp_signal_oe,
  .spare_pin_enable, .spare_pin_assert, .spare_pin_io_out, .spare_pin_io_oe, .local_temp,
  .remote_one_temp, .remote_two_temp, .local_limit, .remote_one_limit, .remote_two_limit,
  .signed_format_select, .voltage_id_pin_function_select, .fan_one_pulse_count
);

// File: dv/overtemp_pin_model.sv
`timescale 1ns/1ps
module overtemp_pin_model
(
  // Drive requests.
  input  wire logic hot,
  input  wire logic oe,
  input  wire logic spare_oe,
  input  wire logic spare_out,
  // Resolved lines.
  output wire logic pin,
  output wire logic spare_pin
);
  // Both lines have pull-ups, so a released line reads high.
  assign pin = ~(hot | oe);
  assign spare_pin = spare_oe ? spare_out : 1'b1;
endmodule

// File: dv/testbench.sv
`timescale 1ns/1ps
`define CHK(a, b) begin compares++; if ((a) !== (b)) begin err_total++; \
  $display("wrong value at %0t: %h vs %h", $time, (a), (b)); end end
module testbench;
  logic       mclk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0, config_lock = 1'b0;
  logic       flag_clear = 1'b0, hot = 1'b0, spare_pin_enable = 1'b0, spare_pin_assert = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, rv;
  logic [7:0] t [3] = '{8'h00, 8'h00, 8'h00};
  logic [7:0] l [3] = '{8'h7F, 8'h7F, 8'h7F};
  logic [7:0] msk [3] = '{8'h40, 8'h20, 8'h80};
  wire  [7:0] reg_rdata;
  wire  [2:0] fan_one_pulse_count, fan_two_pulse_count, fan_three_pulse_count;
  wire  [2:0] fan_four_pulse_count;
  wire        overtemp_time_flag, overtemp_signal_in, overtemp_signal_out, overtemp_signal_oe;
  wire        spare_pin_io_in, spare_pin_io_out, spare_pin_io_oe, signed_format_select;
  wire        offset_full_degree, voltage_id_pin_function_select, spare_pin_level;
  int         err_total = 0, compares = 0, n;

  always #20 mclk = ~mclk;

  thermal_pin_config_registers #(.UNIT_CYCLES(4)) dut
  (
    .mclk, .rst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .config_lock, .flag_clear,
    .overtemp_time_flag, .overtemp_signal_in, .overtemp_signal_out, .overtemp_signal_oe,
    .local_temp(t[0]), .remote_one_temp(t[1]), .remote_two_temp(t[2]), .local_limit(l[0]),
    .remote_one_limit(l[1]), .remote_two_limit(l[2]), .spare_pin_enable, .spare_pin_assert,
    .spare_pin_io_in, .spare_pin_io_out, .spare_pin_io_oe, .spare_pin_level,
    .signed_format_select, .offset_full_degree, .voltage_id_pin_function_select,
    .fan_one_pulse_count, .fan_two_pulse_count, .fan_three_pulse_count, .fan_four_pulse_count
  );

  overtemp_pin_model far
  (
    .hot, .oe(overtemp_signal_oe), .spare_oe(spare_pin_io_oe), .spare_out(spare_pin_io_out),
    .pin(overtemp_signal_in), .spare_pin(spare_pin_io_in)
  );

  task cyc(input int k);
    repeat (k) @(posedge mclk);
    #1;
  endtask
  task wr(input logic [7:0] a, d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [7:0] a, e);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1;
    `CHK(reg_rdata, e)
  endtask
  task cfg(input logic [7:0] v);
    wr(8'h7C, v);
    cyc(2);
  endtask
  task tl(input int i, input logic [7:0] tv, lv);
    @(posedge mclk);
    t[i] <= tv;
    l[i] <= lv;
    cyc(2);
  endtask
  task fans(input logic [7:0] v);
    wr(8'h7B, v);
    cyc(2);
    `CHK(fan_one_pulse_count, {1'b0, v[1:0]} + 3'h1)
    `CHK(fan_two_pulse_count, {1'b0, v[3:2]} + 3'h1)
    `CHK(fan_three_pulse_count, {1'b0, v[5:4]} + 3'h1)
    `CHK(fan_four_pulse_count, {1'b0, v[7:6]} + 3'h1)
  endtask
  task pin(input logic v);
    @(posedge mclk);
    hot <= v;
  endtask
  task wait_flag;
    n = 0;
    while (overtemp_time_flag !== 1'b1 && n < 60)
    begin
      cyc(1);
      n++;
    end
    `CHK(overtemp_time_flag, 1'b1)
    if (overtemp_time_flag !== 1'b1)
      summarize();
  endtask
  task clr;
    @(posedge mclk);
    flag_clear <= 1'b1;
    @(posedge mclk);
    flag_clear <= 1'b0;
    cyc(1);
  endtask
  task summarize;
    $display("compares %0d errors %0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (5) @(posedge mclk);
    rst <= 1'b0;
    rd(8'h7A, 8'h00);
    rd(8'h7B, 8'h55);
    rd(8'h7C, 8'h01);
    `CHK(fan_four_pulse_count, 3'h2)
    fans(8'hE4);
    fans(8'h1B);
    @(posedge mclk);
    spare_pin_enable <= 1'b1;
    spare_pin_assert <= 1'b1;
    cfg(8'h1E);
    `CHK({signed_format_select, offset_full_degree}, 2'h1)
    `CHK(voltage_id_pin_function_select, 1'b1)
    `CHK({spare_pin_io_oe, spare_pin_io_out}, 2'h3)
    cfg(8'h16);
    `CHK({spare_pin_io_oe, spare_pin_io_out}, 2'h2)
    cyc(5);
    `CHK(spare_pin_level, 1'b0)
    cfg(8'h12);
    `CHK(spare_pin_io_oe, 1'b0)
    cyc(5);
    `CHK(spare_pin_level, 1'b1)
    @(posedge mclk);
    config_lock <= 1'b1;
    cfg(8'hFF);
    rd(8'h7C, 8'h12);
    @(posedge mclk);
    config_lock <= 1'b0;
    wr(8'h7E, 8'hA5);
    rd(8'h7E, 8'h00);
    // A short assertion must flag at once yet stay under two timer units.
    pin(1'b1);
    wait_flag();
    pin(1'b0);
    cyc(8);
    `CHK(overtemp_time_flag, 1'b1)
    rd(8'h79, 8'h01);
    rd(8'h79, 8'h00);
    clr();
    `CHK(overtemp_time_flag, 1'b0)
    wr(8'h7A, 8'h03);
    pin(1'b1);
    cyc(19);
    `CHK(overtemp_time_flag, 1'b0)
    wait_flag();
    pin(1'b0);
    cyc(8);
    clr();
    for (int i = 0; i < 3; i++)
    begin
      cfg(msk[i] | 8'h01);
      tl(i, 8'hF0, 8'h40);
      `CHK(overtemp_signal_oe, 1'b0)
      cfg(msk[i]);
      `CHK({overtemp_signal_oe, overtemp_signal_out}, 2'h2)
      tl(i, 8'hF0, 8'h00);
      `CHK(overtemp_signal_oe, 1'b0)
      cfg(msk[i] | 8'h01);
      tl(i, 8'h50, 8'h80);
      `CHK(overtemp_signal_oe, 1'b0)
      tl(i, 8'h50, 8'h40);
      `CHK(overtemp_signal_oe, 1'b1)
      cfg(8'h01);
      `CHK(overtemp_signal_oe, 1'b0)
      tl(i, 8'h00, 8'h7F);
    end
    summarize();
  end
endmodule
